// ==== pmc_consts.svh ====
// constants for the performance monitor control block
// assumes inclusion by bare name from the counter, top, property and bench files
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PMC_OFF_CTRL 4'h0
`define PMC_OFF_CNT_A 4'h4
`define PMC_OFF_CNT_B 4'h8
`define PMC_OFF_MISS 4'hC

// ****************************************************************
// control field positions
// ****************************************************************
`define PMC_NMASK_HI 31
`define PMC_NMASK_LO 24
`define PMC_B_STOP_BIT 23
`define PMC_B_GO_BIT 22
`define PMC_B_SEL_HI 20
`define PMC_B_SEL_LO 16
`define PMC_A_STOP_BIT 15
`define PMC_A_GO_BIT 14
`define PMC_A_SEL_HI 12
`define PMC_A_SEL_LO 8
`define PMC_RATE_HI 3
`define PMC_RATE_LO 2
`define PMC_B_WRAP_BIT 1
`define PMC_A_WRAP_BIT 0

// ****************************************************************
// reset values and answers
// ****************************************************************
`define PMC_RST_NMASK 8'h00
`define PMC_RST_SEL 5'h00
`define PMC_RST_RATE 2'h0
`define PMC_RST_CNT 32'h0000_0000
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

// ****************************************************************
// miss sampling terminal counts (every 32nd, 64th, 128th, 256th)
// ****************************************************************
`define PMC_MISS_TERM_0 8'h1F
`define PMC_MISS_TERM_1 8'h3F
`define PMC_MISS_TERM_2 8'h7F
`define PMC_MISS_TERM_3 8'hFF

`endif

// ==== pmc_counter.sv ====
// one event counter with run state, wrap flag and registered carry
// assumes one-cycle go, stop and clear strobes on the same clock
`timescale 1ns/1ps
`include "pmc_consts.svh"

module pmc_counter
(
   input wire logic clk_i, // module clock
   input wire logic reset_n_i, // synchronous reset, active low
   input wire logic go_i, // start counting
   input wire logic stop_i, // stop counting
   input wire logic clear_i, // zero count and wrap flag
   input wire logic event_i, // selected event this cycle
   output logic [31:0] count_o, // current count
   output logic run_o, // counter running
   output logic wrap_o, // sticky overflow flag
   output logic carry_o // carry out, one cycle late
);

   logic inc;
   logic at_top;

   // increment qualification
   assign inc = run_o & event_i;
   assign at_top = (count_o == 32'hFFFF_FFFF);

   // ****************************************************************
   // run state, count, flag and carry
   // ****************************************************************
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         run_o <= 1'b0;
         count_o <= `PMC_RST_CNT;
         wrap_o <= 1'b0;
         carry_o <= 1'b0;
      end
      else
      begin
         // stop wins when both strobes arrive together
         if (stop_i)
            run_o <= 1'b0;
         else if (go_i)
            run_o <= 1'b1;
         if (clear_i)
            count_o <= `PMC_RST_CNT;
         else if (inc)
            count_o <= count_o + 32'h0000_0001;
         if (inc && at_top)
            wrap_o <= 1'b1;
         else if (clear_i)
            wrap_o <= 1'b0;
         carry_o <= inc & at_top;
      end
   end

endmodule

// ==== pmc_pkg.sv ====
// types shared by the performance monitor control block
// assumes nothing beyond the constants header
package pmc_pkg;

   // ****************************************************************
   // event selector codes
   // ****************************************************************
   typedef enum logic [4:0] {
      EV_RD_MISS = 5'h00,
      EV_WR_MISS = 5'h01,
      EV_SHARED_MISS = 5'h02,
      EV_LOAD_LOCKED = 5'h03,
      EV_STORE_COND_FAIL = 5'h04,
      EV_MAP_HIT = 5'h05,
      EV_BANK_CONFLICT = 5'h06,
      EV_ARB_LOSS = 5'h07,
      EV_VICTIM_HIT = 5'h08,
      EV_CSR_RD = 5'h09,
      EV_CSR_WR = 5'h0A,
      EV_BUS_INTR = 5'h0C,
      EV_MAILBOX_WR = 5'h0D,
      EV_CONSOLE_RD = 5'h0E,
      EV_CONSOLE_WR = 5'h0F,
      EV_MASKED_WR = 5'h10,
      EV_MASKED_VICTIM = 5'h11,
      EV_STALL = 5'h12,
      EV_MEM_LATENCY = 5'h13,
      EV_CASCADE = 5'h14
   } pmc_event_type;

   typedef logic [31:0] pmc_word_type;

endpackage

// ==== pmc_top.sv ====
// performance monitor control register with two counters and miss capture
// assumes an AXI4-Lite master and same-clock event pulses
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pmc_consts.svh"

// Summary of operation
// - eight-bit node mask in control bits 31:24 qualifies masked events
// - mask bit 31 is node 7 downward; bit 24 is node 0 and I/O
// - any mask bits may be set; one mask serves both counters
// - writing one to bit 23 stops the second counter
// - writing one to bit 22 starts the second counter
// - reserved bits 21, 13 and 7:4 read as zero
// - bits 20:16 select the second counter's event
// - bits 12:8 select the first counter's event
// - code 01000: second counts wrapped victim hits, first counts all
// - either counter: 10000 masked writes, 10001 masked victim writes
// - code 10100 counts carry-outs of the other counter
// - writing one to bit 15 stops the first counter
// - writing one to bit 14 starts the first counter
// - bits 3:2 set how often miss address capture loads
// - sample rates 00/01/10/11 are every 32nd/64th/128th/256th miss
// - read-only bit 1 sets on second counter overflow, clears on its reset
// - read-only bit 0 sets on first counter overflow, clears on its reset
// - each counter has own selector, run, halt and overflow bits
module pmc_top
(
   input wire logic clk_i, // 200 MHz module clock
   input wire logic reset_n_i, // synchronous reset, active low
   input wire logic [3:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [3:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [19:0] event_i, // event pulses indexed by code
   input wire logic vb_wrapped_i, // victim hit needed hexword swap
   input wire logic [2:0] src_node_i, // node of masked transaction
   input wire logic src_io_i, // masked transaction from I/O module
   input wire logic miss_i, // miss occurred
   input wire logic [31:0] miss_addr_i // address of that miss
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [7:0] node_mask_q;
   logic [4:0] ctr_a_event_sel_q;
   logic [4:0] ctr_b_event_sel_q;
   logic [1:0] miss_sample_rate_q;
   logic [7:0] miss_cnt_q;
   logic [31:0] miss_address_capture_q;
   logic [3:0] aw_addr_q;
   logic aw_held_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_held_q;
   logic [31:0] event_counter_a;
   logic [31:0] event_counter_b;
   logic ctr_a_run;
   logic ctr_b_run;
   logic ctr_a_wrap_flag;
   logic ctr_b_wrap_flag;
   logic carry_a;
   logic carry_b;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] ctrl_rd;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic wr_go;
   logic wr_hit;
   logic wr_ctrl;
   logic ctr_a_go;
   logic ctr_a_stop;
   logic ctr_b_go;
   logic ctr_b_stop;
   logic clr_a;
   logic clr_b;
   logic node_ok;
   logic masked_wr;
   logic masked_victim;
   logic [31:0] ev_base;
   logic [31:0] ev_vec_a;
   logic [31:0] ev_vec_b;
   logic ev_a;
   logic ev_b;
   logic [7:0] miss_term;
   logic miss_take;

   // ****************************************************************
   // write channel capture
   // ****************************************************************

   // address and data may arrive in either order
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_held_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_held_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (wr_go)
            w_held_q <= 1'b0;
      end
   end

   // write handshake outputs
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMC_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // write decode and byte-lane merge
   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_hit = (aw_addr_q == `PMC_OFF_CTRL) || (aw_addr_q == `PMC_OFF_CNT_A)
      || (aw_addr_q == `PMC_OFF_CNT_B) || (aw_addr_q == `PMC_OFF_MISS);
   assign wr_ctrl = wr_go && (aw_addr_q == `PMC_OFF_CTRL);
   assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   assign wbits = w_data_q & wmask;

   assign ctr_b_stop = wr_ctrl && wbits[`PMC_B_STOP_BIT];
   assign ctr_b_go = wr_ctrl && wbits[`PMC_B_GO_BIT];
   assign ctr_a_stop = wr_ctrl && wbits[`PMC_A_STOP_BIT];
   assign ctr_a_go = wr_ctrl && wbits[`PMC_A_GO_BIT];
   // counter reset by any write to its data word
   assign clr_a = wr_go && (aw_addr_q == `PMC_OFF_CNT_A);
   assign clr_b = wr_go && (aw_addr_q == `PMC_OFF_CNT_B);

   // ****************************************************************
   // control fields
   // ****************************************************************

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         node_mask_q <= `PMC_RST_NMASK;
         ctr_a_event_sel_q <= `PMC_RST_SEL;
         ctr_b_event_sel_q <= `PMC_RST_SEL;
         miss_sample_rate_q <= `PMC_RST_RATE;
      end
      else if (wr_ctrl)
      begin
         if (w_strb_q[3])
            node_mask_q <= w_data_q[`PMC_NMASK_HI:`PMC_NMASK_LO];
         if (w_strb_q[2])
            ctr_b_event_sel_q <= w_data_q[`PMC_B_SEL_HI:`PMC_B_SEL_LO];
         if (w_strb_q[1])
            ctr_a_event_sel_q <= w_data_q[`PMC_A_SEL_HI:`PMC_A_SEL_LO];
         if (w_strb_q[0])
            miss_sample_rate_q <= w_data_q[`PMC_RATE_HI:`PMC_RATE_LO];
      end
   end

   // ****************************************************************
   // event qualification and selection
   // ****************************************************************

   // bit 24 covers node 0 and the I/O module
   assign node_ok = src_io_i ? node_mask_q[0] : node_mask_q[src_node_i];
   assign masked_wr = event_i[pmc_pkg::EV_MASKED_WR] & node_ok;
   assign masked_victim = event_i[pmc_pkg::EV_MASKED_VICTIM] & node_ok;

   // masked events at codes 10000 and 10001
   assign ev_base = {12'h000, event_i[19:18], masked_victim, masked_wr,
      event_i[15:12], 1'b0, event_i[10:0]};
   // first counter sees every victim hit
   // first counter cascades from the second
   assign ev_vec_a = ev_base | {11'h0, carry_b, 20'h00000};
   // second counter sees wrapped victim hits only
   // second counter cascades from the first
   assign ev_vec_b = (ev_base & ~{23'h0, !vb_wrapped_i, 8'h00})
      | {11'h0, carry_a, 20'h00000};
   assign ev_a = ev_vec_a[ctr_a_event_sel_q];
   assign ev_b = ev_vec_b[ctr_b_event_sel_q];

   // ****************************************************************
   // counters
   // ****************************************************************

   // first counter with its own controls
   // first overflow flag cleared by its reset
   pmc_counter u_ctr_a
   (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .go_i(ctr_a_go),
      .stop_i(ctr_a_stop),
      .clear_i(clr_a),
      .event_i(ev_a),
      .count_o(event_counter_a),
      .run_o(ctr_a_run),
      .wrap_o(ctr_a_wrap_flag),
      .carry_o(carry_a)
   );

   // second counter with its own controls
   // second overflow flag cleared by its reset
   pmc_counter u_ctr_b
   (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .go_i(ctr_b_go),
      .stop_i(ctr_b_stop),
      .clear_i(clr_b),
      .event_i(ev_b),
      .count_o(event_counter_b),
      .run_o(ctr_b_run),
      .wrap_o(ctr_b_wrap_flag),
      .carry_o(carry_b)
   );

   // ****************************************************************
   // miss address sampling
   // ****************************************************************

   assign miss_term = (miss_sample_rate_q == 2'h0) ? `PMC_MISS_TERM_0 :
      (miss_sample_rate_q == 2'h1) ? `PMC_MISS_TERM_1 :
      (miss_sample_rate_q == 2'h2) ? `PMC_MISS_TERM_2 : `PMC_MISS_TERM_3;
   assign miss_take = miss_i && (miss_cnt_q >= miss_term);

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         miss_cnt_q <= 8'h00;
         miss_address_capture_q <= 32'h0000_0000;
      end
      else if (miss_i)
      begin
         miss_cnt_q <= miss_take ? 8'h00 : miss_cnt_q + 8'h01;
         if (miss_take)
            miss_address_capture_q <= miss_addr_i;
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************

   // reserved bits and bits 23:22 read zero; bits 15:14 read the run states
   assign ctrl_rd = {node_mask_q, 2'b00, 1'b0, ctr_b_event_sel_q,
      ctr_a_run, ctr_b_run, 1'b0, ctr_a_event_sel_q,
      4'h0, miss_sample_rate_q, ctr_b_wrap_flag, ctr_a_wrap_flag};
   assign rd_hit = (s_axi_araddr == `PMC_OFF_CTRL) || (s_axi_araddr == `PMC_OFF_CNT_A)
      || (s_axi_araddr == `PMC_OFF_CNT_B) || (s_axi_araddr == `PMC_OFF_MISS);
   assign rd_mux = (s_axi_araddr == `PMC_OFF_CTRL) ? ctrl_rd :
      (s_axi_araddr == `PMC_OFF_CNT_A) ? event_counter_a :
      (s_axi_araddr == `PMC_OFF_CNT_B) ? event_counter_b :
      (s_axi_araddr == `PMC_OFF_MISS) ? miss_address_capture_q : 32'h0000_0000;

   // read handshake and data
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PMC_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ==== pmc_top_props.sv ====
// bus handshake and readback assertions for the monitor control block
// assumes binding onto pmc_top, one clock, synchronous active low reset
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_top_props
(
   input wire logic clk_i, // clock
   input wire logic reset_n_i, // reset, active low
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // b response
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [3:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // r response
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready // r ready
);
   logic [3:0] rd_addr_q;

   // address of the read in flight
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
         rd_addr_q <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready)
         rd_addr_q <= s_axi_araddr;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   chk_wr_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read response missing");
   chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   chk_rsvd_zero: assert property (
      s_axi_rvalid && rd_addr_q == `PMC_OFF_CTRL |-> s_axi_rdata[23:21] == 3'h0
      && s_axi_rdata[13] == 1'h0 && s_axi_rdata[7:4] == 4'h0) else $error("reserved bits set");
   chk_bad_addr: assert property (s_axi_rvalid && rd_addr_q[1:0] != 2'h0 |->
      s_axi_rresp == `PMC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read answer");
   chk_good_addr: assert property (s_axi_rvalid && rd_addr_q[1:0] == 2'h0 |->
      s_axi_rresp == `PMC_RESP_OKAY) else $error("mapped read refused");
endmodule

bind pmc_top pmc_top_props u_props (.clk_i, .reset_n_i, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ==== pmc_top_tb.sv ====
// self-checking bench for the monitor control block
// assumes pmc_top with an AXI4-Lite slave and same-clock event inputs
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_top_tb;
   logic clk_i = 1'h0;
   logic reset_n_i = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, miss_addr_i = 32'h0, s_axi_rdata, rd_q;
   logic [19:0] event_i = 20'h0;
   logic [2:0] src_node_i = 3'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp_q;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, vb_wrapped_i = 1'h0;
   logic src_io_i = 1'h0, miss_i = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int failures = 0, n_compared = 0, cycles = 0, lag = 0;

   pmc_top u_dut (.clk_i, .reset_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_i, .vb_wrapped_i, .src_node_i,
      .src_io_i, .miss_i, .miss_addr_i);

   // 200 MHz clock
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end

   // hang guard
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures = failures + 1;
         stop_test();
      end
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task stop_test();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one write, both channels offered together
   // response ready raised after lag edges, so the slave must hold its answer
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      logic done;
      k = 0;
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= (lag == 0);
      do
      begin
         @(posedge clk_i);
         k++;
         if (s_axi_awready === 1'h1)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1)
            s_axi_wvalid <= 1'h0;
         done = (s_axi_bvalid === 1'h1) && (s_axi_bready === 1'h1);
         if (!done && k >= lag)
            s_axi_bready <= 1'h1;
      end while (!done);
      rsp_q = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task rd(input logic [3:0] a);
      int k;
      logic done;
      k = 0;
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= (lag == 0);
      do
      begin
         @(posedge clk_i);
         k++;
         if (s_axi_arready === 1'h1)
            s_axi_arvalid <= 1'h0;
         done = (s_axi_rvalid === 1'h1) && (s_axi_rready === 1'h1);
         if (!done && k >= lag)
            s_axi_rready <= 1'h1;
      end while (!done);
      rd_q = s_axi_rdata;
      rsp_q = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task pulse(input logic [19:0] ev, input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         event_i <= ev;
      end
      @(posedge clk_i);
      event_i <= 20'h0;
   endtask

   // clear both counters, then load control
   task arm(input logic [31:0] ctrl);
      wr(`PMC_OFF_CNT_A, 32'h0, 4'hF);
      wr(`PMC_OFF_CNT_B, 32'h0, 4'hF);
      wr(`PMC_OFF_CTRL, ctrl, 4'hF);
   endtask

   task cnts(input logic [31:0] ea, input logic [31:0] eb);
      rd(`PMC_OFF_CNT_A);
      chk(rd_q, ea);
      rd(`PMC_OFF_CNT_B);
      chk(rd_q, eb);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   // reset state
   task t_reset();
      rd(`PMC_OFF_CTRL);
      chk(rd_q, 32'h0);
      pulse(20'h00001, 3);
      cnts(32'h0, 32'h0);
   endtask

   task t_fields();
      wr(`PMC_OFF_CTRL, 32'hFF3F_3FFC, 4'hF);
      rd(`PMC_OFF_CTRL);
      chk(rd_q, 32'hFF1F_1F0C);
      wr(`PMC_OFF_CTRL, 32'h0, 4'h1);
      rd(`PMC_OFF_CTRL);
      chk(rd_q, 32'hFF1F_1F00);
   endtask

   task t_run();
      arm(32'h0041_4000);
      pulse(20'h00001, 5);
      pulse(20'h00002, 3);
      cnts(32'h5, 32'h3);
      rd(`PMC_OFF_CTRL);
      chk(rd_q, 32'h0001_C000);
      wr(`PMC_OFF_CTRL, 32'h0081_8000, 4'hF);
      pulse(20'h00003, 4);
      cnts(32'h5, 32'h3);
      rd(`PMC_OFF_CTRL);
      chk(rd_q, 32'h0001_0000);
   endtask

   task t_victim();
      arm(32'h0048_4800);
      vb_wrapped_i <= 1'h1;
      pulse(20'h00100, 2);
      vb_wrapped_i <= 1'h0;
      pulse(20'h00100, 3);
      cnts(32'h5, 32'h2);
   endtask

   task t_mask();
      arm(32'h8151_5000);
      for (int n = 0; n < 9; n++)
      begin
         src_node_i <= (n == 8) ? 3'h3 : n[2:0];
         src_io_i <= (n == 8);
         pulse(20'h30000, 1);
      end
      cnts(32'h3, 32'h3);
   endtask

   task t_codes();
      for (int c = 2; c < 20; c++)
      begin
         arm({8'hFF, 3'h2, c[4:0], 3'h2, c[4:0], 8'h00});
         pulse(20'h00001 << c, 2);
         cnts((c == 11) ? 32'h0 : 32'h2, (c == 11 || c == 8) ? 32'h0 : 32'h2);
      end
   endtask

   task t_miss();
      int n;
      logic [31:0] prev;
      prev = 32'h0;
      for (int r = 0; r < 4; r++)
      begin
         wr(`PMC_OFF_CTRL, r << 2, 4'hF);
         n = 32 << r;
         for (int i = 1; i <= n; i++)
         begin
            @(posedge clk_i);
            miss_i <= 1'h1;
            miss_addr_i <= 32'hA000_0000 + (r << 16) + i;
            if (i == n - 1 && r > 0)
            begin
               @(posedge clk_i);
               miss_i <= 1'h0;
               rd(`PMC_OFF_MISS);
               chk(rd_q, prev);
            end
         end
         @(posedge clk_i);
         miss_i <= 1'h0;
         rd(`PMC_OFF_MISS);
         prev = 32'hA000_0000 + (r << 16) + n;
         chk(rd_q, prev);
      end
   endtask

   // unmapped places and strobes
   task t_bus();
      rd(4'h2);
      chk({30'h0, rsp_q}, 32'h2);
      chk(rd_q, 32'h0);
      wr(4'h6, 32'hFFFF_FFFF, 4'hF);
      chk({30'h0, rsp_q}, 32'h2);
      wr(`PMC_OFF_CTRL, 32'hFFFF_FFFF, 4'h0);
      rd(`PMC_OFF_CTRL);
      chk(rd_q, 32'h0000_C00C);
      // late response ready: answer must stand until taken
      lag = 3;
      wr(`PMC_OFF_CTRL, 32'h0000_0008, 4'h1);
      chk({30'h0, rsp_q}, 32'h0);
      rd(`PMC_OFF_CTRL);
      chk(rd_q, 32'h0000_C008);
      lag = 0;
   endtask

   // main sequence
   initial
   begin
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'h1;
      t_reset();
      t_fields();
      t_run();
      t_victim();
      t_mask();
      t_codes();
      t_miss();
      t_bus();
      stop_test();
   end
endmodule
